// >>> pkg/resume_pkg.sv
// constants for the program/erase resume sequencer
// Function
// - opcode d0 requests resume of suspended operation
// - no address; later bytes ignored until deselect
// - restart only after deselect, within resume time
// - clear matching suspend flag on resume
// - busy shown while resumed operation runs
// - program resumes before erase when both suspended
// - suspend requests ignored while resume in progress
// - reset accepted while suspended
package resume_pkg;
    localparam logic [7:0]  OP_RESUME     = 8'hd0;
    localparam logic [7:0]  OP_SUSPEND    = 8'hb0;
    localparam int          CLK_HZ        = 40_000_000;
    localparam int          RESUME_TIME_NS = 1000;
    // longest time rounds down, at least one cycle
    localparam int          RESUME_CYCLES_RAW = (RESUME_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int          RESUME_CYCLES = (RESUME_CYCLES_RAW < 1) ? 1 : RESUME_CYCLES_RAW;
    localparam int          BYTE_BITS     = 8;
    localparam int          OP_BUSY_CYCLES = 64;
endpackage : resume_pkg

// >>> logic/spi_byte_rx.sv
// spi mode 0/3 byte receiver sampled on clk
`timescale 1ns/1ps
`default_nettype none
module spi_byte_rx (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // serial pins, already synchronous
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic       mosi,
    // byte out
    output logic            byte_valid,
    output logic [7:0]      byte_data,
    output logic            first_byte
);
    logic       sck_r,   sck_nxt;
    logic [2:0] cnt_r,   cnt_nxt;
    logic [7:0] sh_r,    sh_nxt;
    logic       v_r,     v_nxt;
    logic [7:0] d_r,     d_nxt;
    logic       first_r, first_nxt;
    logic       seen_r,  seen_nxt;

    always_comb begin
        sck_nxt   = sck;
        cnt_nxt   = cnt_r;
        sh_nxt    = sh_r;
        v_nxt     = 1'b0;
        d_nxt     = d_r;
        first_nxt = first_r;
        seen_nxt  = seen_r;
        if (cs_n) begin
            cnt_nxt  = 3'h0;
            seen_nxt = 1'b0;
        end else if (sck && !sck_r) begin
            sh_nxt  = {sh_r[6:0], mosi};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == 3'h7) begin
                v_nxt     = 1'b1;
                d_nxt     = {sh_r[6:0], mosi};
                first_nxt = !seen_r;
                seen_nxt  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_r   <= 1'b0;
            cnt_r   <= 3'h0;
            sh_r    <= 8'h00;
            v_r     <= 1'b0;
            d_r     <= 8'h00;
            first_r <= 1'b0;
            seen_r  <= 1'b0;
        end else begin
            sck_r   <= sck_nxt;
            cnt_r   <= cnt_nxt;
            sh_r    <= sh_nxt;
            v_r     <= v_nxt;
            d_r     <= d_nxt;
            first_r <= first_nxt;
            seen_r  <= seen_nxt;
        end
    end

    assign byte_valid = v_r;
    assign byte_data  = d_r;
    assign first_byte = first_r;
endmodule : spi_byte_rx
`default_nettype wire

// >>> logic/program_erase_resume.sv
// resume sequencer: decodes resume/suspend, restarts suspended work
`timescale 1ns/1ps
`default_nettype none
module program_erase_resume #(
    parameter int RESUME_CYCLES = resume_pkg::RESUME_CYCLES,
    parameter int BUSY_CYCLES   = resume_pkg::OP_BUSY_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // spi pins
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic mosi,
    // software reset command, one-cycle pulse
    input  wire logic soft_reset,
    // suspend state loaded by the suspend logic, one-cycle pulse
    input  wire logic set_buf1_susp,
    input  wire logic set_buf2_susp,
    input  wire logic set_erase_susp,
    // status
    output logic      buffer1_program_suspended_flag,
    output logic      buffer2_program_suspended_flag,
    output logic      erase_suspended_flag,
    output logic      ready,
    output logic      resuming,
    output logic      suspend_ignored
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_RES   = 4'b0100,
        ST_RUN   = 4'b1000
    } state_e;

    logic       bv;
    logic [7:0] bd;
    logic       bfirst;

    spi_byte_rx u_rx (
        .clk        (clk),
        .reset_n    (reset_n),
        .cs_n       (cs_n),
        .sck        (sck),
        .mosi       (mosi),
        .byte_valid (bv),
        .byte_data  (bd),
        .first_byte (bfirst)
    );

    state_e      st_r,   st_nxt;
    logic        b1_r,   b1_nxt;
    logic        b2_r,   b2_nxt;
    logic        es_r,   es_nxt;
    logic        rdy_r,  rdy_nxt;
    logic        ign_r,  ign_nxt;
    logic        cs_d_r;
    logic [15:0] cnt_r,  cnt_nxt;
    logic        is_prog_r, is_prog_nxt;
    // pin comes from a flop, not from the state decode
    logic        resuming_r, resuming_nxt;

    wire any_susp = b1_r | b2_r | es_r;
    wire deselect = cs_n && !cs_d_r;
    wire op_res   = bv && bfirst && bd == resume_pkg::OP_RESUME;
    wire op_susp  = bv && bfirst && bd == resume_pkg::OP_SUSPEND;

    always_comb begin
        st_nxt      = st_r;
        b1_nxt      = b1_r | set_buf1_susp;
        b2_nxt      = b2_r | set_buf2_susp;
        es_nxt      = es_r | set_erase_susp;
        rdy_nxt     = rdy_r;
        ign_nxt     = 1'b0;
        cnt_nxt     = cnt_r;
        is_prog_nxt = is_prog_r;
        if (set_buf1_susp || set_buf2_susp || set_erase_susp) begin
            rdy_nxt = 1'b1;
            st_nxt  = ST_IDLE;
        end
        unique case (st_r)
            ST_IDLE: begin
                // trailing bytes are never decoded, only the opcode
                if (op_res && any_susp) begin
                    st_nxt = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (deselect) begin
                    st_nxt  = ST_RES;
                    cnt_nxt = 16'(RESUME_CYCLES);
                    rdy_nxt = 1'b0;
                    if (b1_r || b2_r) begin
                        is_prog_nxt = 1'b1;
                        // a new suspend in the same cycle wins over the clear
                        if (b1_r) b1_nxt = set_buf1_susp;
                        else b2_nxt = set_buf2_susp;
                    end else begin
                        is_prog_nxt = 1'b0;
                        es_nxt      = set_erase_susp;
                    end
                end
            end
            ST_RES: begin
                // nothing but a reset cuts the resume window short
                st_nxt  = ST_RES;
                rdy_nxt = 1'b0;
                if (op_susp) ign_nxt = 1'b1;
                if (cnt_r <= 16'h0001) begin
                    st_nxt  = ST_RUN;
                    cnt_nxt = 16'(BUSY_CYCLES);
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            ST_RUN: begin
                if (cnt_r <= 16'h0001) begin
                    st_nxt  = ST_IDLE;
                    rdy_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        if (soft_reset) begin
            st_nxt  = ST_IDLE;
            b1_nxt  = 1'b0;
            b2_nxt  = 1'b0;
            es_nxt  = 1'b0;
            rdy_nxt = 1'b1;
        end
        resuming_nxt = (st_nxt == ST_RES);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r      <= ST_IDLE;
            b1_r      <= 1'b0;
            b2_r      <= 1'b0;
            es_r      <= 1'b0;
            rdy_r     <= 1'b1;
            ign_r     <= 1'b0;
            cs_d_r    <= 1'b1;
            cnt_r     <= 16'h0000;
            is_prog_r <= 1'b0;
            resuming_r <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            b1_r      <= b1_nxt;
            b2_r      <= b2_nxt;
            es_r      <= es_nxt;
            rdy_r     <= rdy_nxt;
            ign_r     <= ign_nxt;
            cs_d_r    <= cs_n;
            cnt_r     <= cnt_nxt;
            is_prog_r <= is_prog_nxt;
            resuming_r <= resuming_nxt;
        end
    end

    assign buffer1_program_suspended_flag = b1_r;
    assign buffer2_program_suspended_flag = b2_r;
    assign erase_suspended_flag           = es_r;
    assign ready                          = rdy_r;
    assign resuming                       = resuming_r;
    assign suspend_ignored                = ign_r;

    property p_restart_on_deselect;
        @(posedge clk) disable iff (!reset_n)
        (st_r == ST_ARMED && deselect && !soft_reset) |=> st_r == ST_RES && !rdy_r;
    endproperty
    a_restart_on_deselect: assert property (p_restart_on_deselect) else $error("no restart at deselect");

    property p_prog_first;
        @(posedge clk) disable iff (!reset_n)
        (st_r == ST_ARMED && deselect && es_r && b1_r && !soft_reset && !set_buf1_susp) |=> es_r && !b1_r;
    endproperty
    a_prog_first: assert property (p_prog_first) else $error("erase resumed before program");

    property p_noop;
        @(posedge clk) disable iff (!reset_n)
        (st_r == ST_IDLE && op_res && !any_susp) |=> st_r == ST_IDLE;
    endproperty
    a_noop: assert property (p_noop) else $error("resume without suspend acted");

    property p_busy;
        @(posedge clk) disable iff (!reset_n)
        (st_r == ST_RES || st_r == ST_RUN) |-> !rdy_r;
    endproperty
    a_busy: assert property (p_busy) else $error("ready while resumed op runs");

    property p_ignore;
        @(posedge clk) disable iff (!reset_n)
        (st_r == ST_RES && op_susp) |=> suspend_ignored;
    endproperty
    a_ignore: assert property (p_ignore) else $error("suspend not ignored");

    property p_soft_reset;
        @(posedge clk) disable iff (!reset_n)
        soft_reset |=> !any_susp && rdy_r && st_r == ST_IDLE;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset not taken");

    property p_flag_clear;
        @(posedge clk) disable iff (!reset_n)
        (st_r == ST_ARMED && deselect && !es_r && b2_r && !b1_r && !soft_reset && !set_buf2_susp) |=> !b2_r;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("suspend flag not cleared");

    property p_res_len;
        @(posedge clk) disable iff (!reset_n)
        $rose(resuming) |-> ##[1:300] !resuming;
    endproperty
    a_res_len: assert property (p_res_len) else $error("resume took too long");

    property p_erase_waits;
        @(posedge clk) disable iff (!reset_n)
        (st_r == ST_RES && is_prog_r && es_r && !soft_reset) |=> es_r;
    endproperty
    a_erase_waits: assert property (p_erase_waits) else $error("erase resumed with program");

    property p_ign_only;
        @(posedge clk) disable iff (!reset_n)
        !(st_r == ST_RES && op_susp) |=> !suspend_ignored;
    endproperty
    a_ign_only: assert property (p_ign_only) else $error("ignore pulse outside resume");
endmodule : program_erase_resume
`default_nettype wire

// >>> verif/spi_host.sv
// spi host model that sends command bytes
`timescale 1ns/1ps
`default_nettype none
module spi_host (
    // clock
    input  wire logic clk,
    // spi pins
    output logic      cs_n,
    output logic      sck,
    output logic      mosi
);
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        mosi = 1'b1;
    end
    // sck idles low between frames; bytes after the first are filler
    task automatic xfer(input logic [7:0] op, input logic [7:0] fill, input int n);
        logic [7:0] b;
        @(negedge clk);
        cs_n = 1'b0;
        for (int k = 0; k < n; k++) begin
            b = (k == 0) ? op : fill;
            for (int i = 7; i >= 0; i--) begin
                @(negedge clk);
                sck  = 1'b0;
                mosi = b[i];
                @(negedge clk);
                sck = 1'b1;
            end
        end
        @(negedge clk);
        sck = 1'b0;
        @(negedge clk);
        cs_n = 1'b1;
        // released line must not keep its last bit
        mosi = ~mosi;
    endtask : xfer
endmodule : spi_host
`default_nettype wire

// >>> verif/program_erase_resume_tb.sv
// self-checking bench for the resume sequencer
`timescale 1ns/1ps
`default_nettype none
module program_erase_resume_tb;
    logic       clk = 1'b0;
    logic       reset_n, soft_reset, s1, s2, se;
    wire logic  cs_n, sck, mosi;
    logic       f1, f2, fe, ready, resuming, ign;
    logic [2:0] cur;
    int         errors = 0, num_checks = 0, n_ign = 0, seed = 32'h1645;
    always #12.5 clk = ~clk;
    always @(posedge clk) if (ign === 1'b1) n_ign++;
    spi_host i_spi_host (.clk(clk), .cs_n(cs_n), .sck(sck), .mosi(mosi));
    // short busy time keeps the run brief
    program_erase_resume #(.BUSY_CYCLES(4)) i_program_erase_resume (.clk(clk), .reset_n(reset_n),
        .cs_n(cs_n), .sck(sck), .mosi(mosi), .soft_reset(soft_reset), .set_buf1_susp(s1),
        .set_buf2_susp(s2), .set_erase_susp(se), .buffer1_program_suspended_flag(f1),
        .buffer2_program_suspended_flag(f2), .erase_suspended_flag(fe), .ready(ready),
        .resuming(resuming), .suspend_ignored(ign));
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    function automatic logic [2:0] after_resume(input logic [2:0] f);
        // program buffers go before erase
        if (f[2]) return {1'b0, f[1:0]};
        if (f[1]) return {2'b00, f[0]};
        return 3'b000;
    endfunction : after_resume
    task automatic wait_ready;
        for (int n = 0; n < 400; n++) begin
            if (ready === 1'b1) begin
                chk("idle_after_run", 4'h0, {3'b000, resuming});
                return;
            end
            @(negedge clk);
        end
        chk("ready_wait", 4'h1, 4'h0);
        wrap_up();
    endtask : wait_ready
    task automatic suspend(input logic [2:0] f);
        @(negedge clk);
        {s1, s2, se} = f;
        cur = cur | f;
        @(negedge clk);
        {s1, s2, se} = 3'b000;
        @(negedge clk);
        chk("susp", {cur, 1'b1}, {f1, f2, fe, ready});
    endtask : suspend
    task automatic resume(input int extra);
        logic busy;
        i_spi_host.xfer(resume_pkg::OP_RESUME, 8'($random(seed)), 1 + extra);
        chk("held", {cur, 1'b1}, {f1, f2, fe, ready});
        busy = (cur != 3'b000);
        cur = after_resume(cur);
        repeat (3) @(negedge clk);
        chk("resumed", {cur, ~busy}, {f1, f2, fe, ready});
        if (busy) chk("resuming", 4'h1, {3'b000, resuming});
    endtask : resume
    initial begin
        logic [7:0] op;
        {reset_n, soft_reset, s1, s2, se} = 5'b00000;
        cur = 3'b000;
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        chk("reset", 4'h1, {f1, f2, fe, ready});
        resume(1);
        suspend(3'b101);
        resume(2);
        i_spi_host.xfer(resume_pkg::OP_SUSPEND, 8'h00, 1);
        // the one-cycle pulse is counted at the edge that ends it
        repeat (2) @(negedge clk);
        chk("ignored", 4'h1, 4'(n_ign));
        chk("still_busy", {cur, 1'b0}, {f1, f2, fe, ready});
        wait_ready();
        resume(0);
        wait_ready();
        for (int k = 0; k < 6; k++) begin
            suspend(3'($random(seed)));
            op = 8'($random(seed));
            if (op == resume_pkg::OP_RESUME) op = 8'h3c;
            i_spi_host.xfer(op, 8'h00, 1);
            repeat (3) @(negedge clk);
            chk("other_op", {cur, 1'b1}, {f1, f2, fe, ready});
            resume(k % 3);
            wait_ready();
        end
        suspend(3'b111);
        soft_reset = 1'b1;
        @(negedge clk);
        soft_reset = 1'b0;
        @(negedge clk);
        cur = 3'b000;
        chk("soft_reset", 4'h1, {f1, f2, fe, ready});
        suspend(3'b010);
        reset_n = 1'b0;
        @(negedge clk);
        chk("hard_reset", 4'h1, {f1, f2, fe, ready});
        reset_n = 1'b1;
        cur = 3'b000;
        resume(0);
        suspend(3'b010);
        resume(1);
        wait_ready();
        wrap_up();
    end
endmodule : program_erase_resume_tb
`default_nettype wire
